// ---- qba_pkg.sv ----
`default_nettype none
package qba_pkg;
	// ==========================================================
	// widths
	localparam int LEN_W = 14;
	localparam int ADJ_W = 15;
	localparam int SZ_W = 18;
	localparam int BYTES_W = 28;
	localparam int AMT_W = 7;
	localparam int PCT_W = 7;
	localparam int STAT_W = 32;
	localparam int LEAK_W = 16;

	// ==========================================================
	// legal ranges of the settings and the kilobyte scale
	localparam logic [SZ_W-1:0] BURST_MIN = 18'h00001;
	localparam logic [SZ_W-1:0] BURST_MAX = 18'h036b0; // 14000
	localparam logic [SZ_W-1:0] BUF_MAX = 18'h20000; // 131072
	localparam logic [PCT_W-1:0] PCT_MAX = 7'h64; // 100 percent
	localparam logic [AMT_W-1:0] ADD_MAX = 7'h20; // 32 bytes
	localparam logic [AMT_W-1:0] SUB_MAX = 7'h40; // 64 bytes
	localparam logic [BYTES_W-1:0] KB_BYTES = 28'h00003e8; // 1000

	// ==========================================================
	// values after reset, all in bytes except the percentage
	localparam logic [BYTES_W-1:0] BURST_SYS_RST = 28'h0002710;
	localparam logic [BYTES_W-1:0] CBS_RST = 28'h0000000;
	localparam logic [BYTES_W-1:0] MBS_RST = 28'h000fa00;
	localparam logic [PCT_W-1:0] HP_PCT_RST = 7'h0a;
	localparam logic [AMT_W-1:0] ADJ_AMT_RST = 7'h00;

	// ==========================================================
	// burst threshold commands
	typedef enum logic [1:0] {
		BURST_SET_POLICY,
		BURST_SET_INST,
		BURST_CLR_POLICY,
		BURST_CLR_INST
	} burst_op_t;

	// ==========================================================
	// helpers
	// kilobyte settings become bytes so every compare after the range checks sees one unit
	function automatic logic [BYTES_W-1:0] to_bytes(input logic [SZ_W-1:0] v,
		input logic in_bytes);
		logic [BYTES_W-1:0] w;
		w = {{(BYTES_W-SZ_W){1'b0}}, v};
		return in_bytes ? w : BYTES_W'(w * KB_BYTES);
	endfunction

	// subtract clamps at zero so counters never take a negative step
	function automatic logic [ADJ_W-1:0] adjust_len(input logic [LEN_W-1:0] len,
		input logic sub, input logic [AMT_W-1:0] amt);
		logic [ADJ_W-1:0] l;
		logic [ADJ_W-1:0] a;
		l = {1'b0, len};
		a = {{(ADJ_W-AMT_W){1'b0}}, amt};
		if (sub) begin
			return (l > a) ? ADJ_W'(l - a) : '0;
		end
		return ADJ_W'(l + a);
	endfunction
endpackage
`default_nettype wire

// ---- size_adj_if.sv ----
`default_nettype none
interface size_adj_if;
	import qba_pkg::*;
	// ==========================================================
	// adjustment setting plus arrival and drain lengths
	logic sub_sel;
	logic [AMT_W-1:0] amount;
	logic [LEN_W-1:0] arr_len;
	logic [LEN_W-1:0] drn_len;
	logic [ADJ_W-1:0] arr_adj;
	logic [ADJ_W-1:0] drn_adj;
	modport user (output sub_sel, output amount, output arr_len, output drn_len,
		input arr_adj, input drn_adj);
	modport unit (input sub_sel, input amount, input arr_len, input drn_len,
		output arr_adj, output drn_adj);
endinterface
`default_nettype wire

// ---- packet_size_adjust.sv ----
`default_nettype none
module packet_size_adjust
	import qba_pkg::*;
(
	size_adj_if.unit sa
);
	// ==========================================================
	// accounting lengths; the frame itself is never touched
	assign sa.arr_adj = adjust_len(sa.arr_len, sa.sub_sel, sa.amount);
	assign sa.drn_adj = adjust_len(sa.drn_len, sa.sub_sel, sa.amount);
endmodule
`default_nettype wire

// ---- queue_buffer_admission_shaping.sv ----
// Functional notes
// - burst threshold is shaping bucket fill level
// - burst size 1..14000, kilobytes unless bytes
// - instance clear uses policy; policy clear uses default
// - reserved size 0..131072 kilobytes
// - reject changes leaving reserved above maximum
// - oversubscribed pool may refuse below reserved
// - high-priority-only share 0..100 percent
// - high-priority reserve only on ingress queues
// - above maximum, discard until drained
// - maximum 0..131072; zero discards everything
// - congestion grants follow drop slope decision
// - adjustment changes accounting length only
// - adjusted length feeds buckets, rates, statistics
// - port scheduler uses true wire length
// - add 0..32 or subtract 0..64, one direction
// - wire accounting caps rate, adjustment stays; the code only reports it on wire_cap_out
`default_nettype none
module queue_buffer_admission_shaping
	import qba_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	input wire logic burst_wr_in,
	input wire burst_op_t burst_op_in,
	input wire logic [SZ_W-1:0] burst_size_in,
	input wire logic burst_in_bytes_in,
	input wire logic cbs_wr_in,
	input wire logic [SZ_W-1:0] cbs_kb_in,
	input wire logic mbs_wr_in,
	input wire logic [SZ_W-1:0] mbs_size_in,
	input wire logic mbs_in_bytes_in,
	input wire logic hp_wr_in,
	input wire logic [PCT_W-1:0] hp_pct_in,
	input wire logic adj_wr_in,
	input wire logic adj_sub_in,
	input wire logic [AMT_W-1:0] adj_amount_in,
	input wire logic ingress_queue_in,
	input wire logic wire_acct_en_in,
	input wire logic pool_oversub_in,
	input wire logic pkt_valid_in,
	input wire logic [LEN_W-1:0] pkt_len_in,
	input wire logic pkt_high_prio_in,
	input wire logic red_grant_in,
	input wire logic drain_valid_in,
	input wire logic [LEN_W-1:0] drain_len_in,
	input wire logic [LEAK_W-1:0] shape_leak_in,
	output logic cfg_err_out,
	output logic pkt_done_out,
	output logic pkt_accept_out,
	output logic pkt_drop_out,
	output logic [ADJ_W-1:0] pkt_acct_len_out,
	output logic tx_done_out,
	output logic [ADJ_W-1:0] tx_acct_len_out,
	output logic [LEN_W-1:0] tx_wire_len_out,
	output logic shape_open_out,
	output logic [BYTES_W-1:0] burst_bytes_out,
	output logic [BYTES_W-1:0] occupancy_out,
	output logic [STAT_W-1:0] stat_bytes_out,
	output logic wire_cap_out
);
	// ==========================================================
	// state
	logic [BYTES_W-1:0] pol_burst_q, inst_burst_q, burst_q, cbs_q, mbs_q, lp_limit_q;
	logic [BYTES_W-1:0] occ_q, bucket_q;
	logic [PCT_W-1:0] hp_q;
	logic [AMT_W-1:0] adj_amt_q;
	logic [STAT_W-1:0] stat_q;
	logic [ADJ_W-1:0] pkt_acct_q, tx_acct_q;
	logic [LEN_W-1:0] tx_wire_q;
	logic inst_valid_q, adj_sub_q, cfg_err_q, pkt_done_q, pkt_accept_q, pkt_drop_q;
	logic tx_done_q, shape_open_q, wire_cap_q;

	size_adj_if sa ();

	// ==========================================================
	// accounting length unit
	assign sa.sub_sel = adj_sub_q;
	assign sa.amount = adj_amt_q;
	assign sa.arr_len = pkt_len_in;
	assign sa.drn_len = drain_len_in;

	packet_size_adjust packet_size_adjust_inst (.sa(sa.unit));

	// ==========================================================
	// configuration checks
	logic burst_set, burst_bad, cbs_range_bad, mbs_range_bad, rel_bad, hp_bad, adj_bad;
	logic [BYTES_W-1:0] burst_cand, cbs_cand, mbs_cand;

	// both buffer limits are compared as bytes against the candidate pair
	always_comb begin
		burst_set = (burst_op_in == BURST_SET_POLICY) || (burst_op_in == BURST_SET_INST);
		burst_bad = burst_wr_in && burst_set &&
			((burst_size_in < BURST_MIN) || (burst_size_in > BURST_MAX));
		burst_cand = to_bytes(burst_size_in, burst_in_bytes_in);
		cbs_range_bad = cbs_wr_in && (cbs_kb_in > BUF_MAX);
		mbs_range_bad = mbs_wr_in && (mbs_size_in > BUF_MAX);
		cbs_cand = cbs_wr_in ? to_bytes(cbs_kb_in, 1'b0) : cbs_q;
		mbs_cand = mbs_wr_in ? to_bytes(mbs_size_in, mbs_in_bytes_in) : mbs_q;
		rel_bad = (cbs_wr_in || mbs_wr_in) && (cbs_cand > mbs_cand);
		hp_bad = hp_wr_in && (hp_pct_in > PCT_MAX);
		adj_bad = adj_wr_in && (adj_sub_in ? (adj_amount_in > SUB_MAX) :
			(adj_amount_in > ADD_MAX));
	end

	// one pulse per rejected write cycle; a rejected write stores nothing
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			cfg_err_q <= 1'b0;
		end else begin
			cfg_err_q <= burst_bad || cbs_range_bad || mbs_range_bad || rel_bad ||
				hp_bad || adj_bad;
		end
	end

	// ==========================================================
	// burst threshold: policy value, instance override, system default
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			pol_burst_q <= BURST_SYS_RST;
			inst_burst_q <= BURST_SYS_RST;
			inst_valid_q <= 1'b0;
		end else if (burst_wr_in && !burst_bad) begin
			unique case (burst_op_in)
				BURST_SET_POLICY: pol_burst_q <= burst_cand;
				BURST_SET_INST: begin
					inst_burst_q <= burst_cand;
					inst_valid_q <= 1'b1;
				end
				BURST_CLR_POLICY: pol_burst_q <= BURST_SYS_RST;
				BURST_CLR_INST: inst_valid_q <= 1'b0;
			endcase
		end
	end

	// effective threshold, the override wins while present
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			burst_q <= BURST_SYS_RST;
		end else begin
			burst_q <= inst_valid_q ? inst_burst_q : pol_burst_q;
		end
	end

	// ==========================================================
	// buffer limits; a pair that breaks the order is dropped whole
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			cbs_q <= CBS_RST;
			mbs_q <= MBS_RST;
		end else if (!rel_bad && !cbs_range_bad && !mbs_range_bad) begin
			if (cbs_wr_in) begin
				cbs_q <= cbs_cand;
			end
			if (mbs_wr_in) begin
				mbs_q <= mbs_cand;
			end
		end
	end

	// high-priority share and the limit left for other packets
	logic [BYTES_W+PCT_W-1:0] hp_prod;
	logic [BYTES_W-1:0] hp_share;

	// division is costly, so the limit is refreshed one cycle late
	always_comb begin
		hp_prod = {{PCT_W{1'b0}}, mbs_q} * {{BYTES_W{1'b0}}, hp_q};
		hp_share = BYTES_W'(hp_prod / {{BYTES_W{1'b0}}, PCT_MAX});
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			hp_q <= HP_PCT_RST;
			lp_limit_q <= '0;
		end else begin
			if (hp_wr_in && !hp_bad) begin
				hp_q <= hp_pct_in;
			end
			lp_limit_q <= mbs_q - hp_share;
		end
	end

	// size adjustment setting, direction and amount written together
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			adj_sub_q <= 1'b0;
			adj_amt_q <= ADJ_AMT_RST;
		end else if (adj_wr_in && !adj_bad) begin
			adj_sub_q <= adj_sub_in;
			adj_amt_q <= adj_amount_in;
		end
	end

	// ==========================================================
	// admission decision
	logic within_mbs, hp_block, reserved_ok, accept;

	always_comb begin
		within_mbs = (mbs_q != '0) && (occ_q <= mbs_q);
		hp_block = ingress_queue_in && !pkt_high_prio_in && (occ_q > lp_limit_q);
		reserved_ok = (occ_q < cbs_q) && !pool_oversub_in;
		accept = within_mbs && !hp_block && (reserved_ok || red_grant_in);
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			pkt_done_q <= 1'b0;
			pkt_accept_q <= 1'b0;
			pkt_drop_q <= 1'b0;
			pkt_acct_q <= '0;
		end else begin
			pkt_done_q <= pkt_valid_in;
			pkt_accept_q <= pkt_valid_in && accept;
			pkt_drop_q <= pkt_valid_in && !accept;
			if (pkt_valid_in) begin
				pkt_acct_q <= sa.arr_adj;
			end
		end
	end

	// ==========================================================
	// occupancy in true bytes, floored so a stray drain cannot wrap
	logic [BYTES_W-1:0] occ_add, occ_sum, occ_sub;

	always_comb begin
		occ_add = (pkt_valid_in && accept) ? {{(BYTES_W-LEN_W){1'b0}}, pkt_len_in} : '0;
		occ_sub = drain_valid_in ? {{(BYTES_W-LEN_W){1'b0}}, drain_len_in} : '0;
		occ_sum = BYTES_W'(occ_q + occ_add);
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			occ_q <= '0;
		end else begin
			occ_q <= (occ_sum > occ_sub) ? BYTES_W'(occ_sum - occ_sub) : '0;
		end
	end

	// ==========================================================
	// shaping bucket fills with adjusted drained bytes, leaks per cycle
	logic [BYTES_W-1:0] bkt_sum, bkt_leak, bkt_d;

	always_comb begin
		bkt_sum = BYTES_W'(bucket_q + (drain_valid_in ?
			{{(BYTES_W-ADJ_W){1'b0}}, sa.drn_adj} : '0));
		bkt_leak = {{(BYTES_W-LEAK_W){1'b0}}, shape_leak_in};
		bkt_d = (bkt_sum > bkt_leak) ? BYTES_W'(bkt_sum - bkt_leak) : '0;
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			bucket_q <= '0;
			shape_open_q <= 1'b0;
		end else begin
			bucket_q <= bkt_d;
			shape_open_q <= bkt_d < burst_q;
		end
	end

	// ==========================================================
	// transmit report: accounting length and untouched wire length
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			tx_done_q <= 1'b0;
			tx_acct_q <= '0;
			tx_wire_q <= '0;
			wire_cap_q <= 1'b0;
		end else begin
			tx_done_q <= drain_valid_in;
			wire_cap_q <= wire_acct_en_in;
			if (drain_valid_in) begin
				tx_acct_q <= sa.drn_adj;
				tx_wire_q <= drain_len_in;
			end
		end
	end

	// accepted bytes counter, in adjusted length
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			stat_q <= '0;
		end else if (pkt_valid_in && accept) begin
			stat_q <= STAT_W'(stat_q + {{(STAT_W-ADJ_W){1'b0}}, sa.arr_adj});
		end
	end

	// ==========================================================
	// outputs
	assign cfg_err_out = cfg_err_q;
	assign pkt_done_out = pkt_done_q;
	assign pkt_accept_out = pkt_accept_q;
	assign pkt_drop_out = pkt_drop_q;
	assign pkt_acct_len_out = pkt_acct_q;
	assign tx_done_out = tx_done_q;
	assign tx_acct_len_out = tx_acct_q;
	assign tx_wire_len_out = tx_wire_q;
	assign shape_open_out = shape_open_q;
	assign burst_bytes_out = burst_q;
	assign occupancy_out = occ_q;
	assign stat_bytes_out = stat_q;
	assign wire_cap_out = wire_cap_q;

	// ==========================================================
	// checks
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);

	sequence s_arrive;
		pkt_valid_in;
	endsequence
	sequence s_report;
		pkt_done_out ##0 (pkt_accept_out != pkt_drop_out);
	endsequence

	property p_decision;
		s_arrive |=> s_report;
	endproperty
	a_decision: assert property (p_decision) else $error("no single verdict");
	property p_zero_mbs;
		pkt_valid_in && (mbs_q == '0) |=> pkt_drop_out;
	endproperty
	a_zero_mbs: assert property (p_zero_mbs) else $error("zero max admitted");
	property p_over_mbs;
		pkt_valid_in && (occ_q > mbs_q) |=> pkt_drop_out && !pkt_accept_out;
	endproperty
	a_over_mbs: assert property (p_over_mbs) else $error("admitted above max");
	property p_order;
		cbs_q <= mbs_q;
	endproperty
	a_order: assert property (p_order) else $error("reserved above max");
	property p_order_err;
		(cbs_wr_in || mbs_wr_in) && (cbs_cand > mbs_cand) |=> cfg_err_out && $stable(cbs_q)
			&& $stable(mbs_q);
	endproperty
	a_order_err: assert property (p_order_err) else $error("bad pair not refused");
	property p_burst_range;
		burst_wr_in && burst_set && (burst_size_in == '0) |=> cfg_err_out ##1
			(burst_bytes_out == $past(burst_bytes_out));
	endproperty
	a_burst_range: assert property (p_burst_range) else $error("zero burst taken");
	property p_inst_clear;
		burst_wr_in && (burst_op_in == BURST_CLR_INST) |=> ##1
			(burst_bytes_out == $past(pol_burst_q));
	endproperty
	a_inst_clear: assert property (p_inst_clear) else $error("override kept");
	property p_oversub;
		pkt_valid_in && pool_oversub_in && !red_grant_in |=> !pkt_accept_out;
	endproperty
	a_oversub: assert property (p_oversub) else $error("oversubscribed grant");
	property p_hp_reserve;
		pkt_valid_in && ingress_queue_in && !pkt_high_prio_in && (occ_q > lp_limit_q)
			|=> pkt_drop_out;
	endproperty
	a_hp_reserve: assert property (p_hp_reserve) else $error("low prio in reserve");
	property p_wire_len;
		drain_valid_in |=> tx_done_out && (tx_wire_len_out == $past(drain_len_in));
	endproperty
	a_wire_len: assert property (p_wire_len) else $error("wire length altered");
	property p_clamp;
		pkt_valid_in && adj_sub_q && ({{(ADJ_W-LEN_W){1'b0}}, pkt_len_in} <=
			{{(ADJ_W-AMT_W){1'b0}}, adj_amt_q}) |=> (pkt_acct_len_out == '0);
	endproperty
	a_clamp: assert property (p_clamp) else $error("negative length");
endmodule
`default_nettype wire

// ---- queue_partner.sv ----
`default_nettype none
module queue_partner
	import qba_pkg::*;
(
	input wire logic core_clk_in,
	output logic pkt_valid_out,
	output logic [LEN_W-1:0] pkt_len_out,
	output logic pkt_high_prio_out,
	output logic red_grant_out,
	output logic drain_valid_out,
	output logic [LEN_W-1:0] drain_len_out,
	output logic [LEAK_W-1:0] shape_leak_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// idle levels at time zero, nothing offered and nothing leaking
	initial begin
		pkt_valid_out = 1'b0;
		pkt_len_out = '0;
		pkt_high_prio_out = 1'b0;
		red_grant_out = 1'b0;
		drain_valid_out = 1'b0;
		drain_len_out = '0;
		shape_leak_out = '0;
	end

	// ==========================================================
	// upstream enqueue: one arrival, changed only at falling edges
	task automatic arrive(input logic [LEN_W-1:0] len, input logic hi, input logic grant);
		@(negedge core_clk_in);
		pkt_valid_out = 1'b1;
		pkt_len_out = len;
		pkt_high_prio_out = hi;
		red_grant_out = grant;
		@(negedge core_clk_in);
		pkt_valid_out = 1'b0;
		// released qualifiers flip so a stale value can never look right
		pkt_len_out = ~len;
		pkt_high_prio_out = ~hi;
		red_grant_out = ~grant;
	endtask

	// ==========================================================
	// downstream scheduler: one departure of a true-length frame
	task automatic depart(input logic [LEN_W-1:0] len);
		@(negedge core_clk_in);
		drain_valid_out = 1'b1;
		drain_len_out = len;
		@(negedge core_clk_in);
		drain_valid_out = 1'b0;
		drain_len_out = ~len;
	endtask

	// leak rate is a level the scheduler holds until told otherwise
	task automatic set_leak(input logic [LEAK_W-1:0] leak);
		@(negedge core_clk_in);
		shape_leak_out = leak;
	endtask
endmodule
`default_nettype wire

// ---- queue_buffer_admission_shaping_test.sv ----
`default_nettype none
module queue_buffer_admission_shaping_test;
	import qba_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// stimulus and observed signals
	logic core_clk_in, rst_b_in, burst_wr_in, burst_in_bytes_in, cbs_wr_in, mbs_wr_in;
	burst_op_t burst_op_in;
	logic [SZ_W-1:0] burst_size_in, cbs_kb_in, mbs_size_in;
	logic mbs_in_bytes_in, hp_wr_in, adj_wr_in, adj_sub_in;
	logic [PCT_W-1:0] hp_pct_in;
	logic [AMT_W-1:0] adj_amount_in;
	logic ingress_queue_in, wire_acct_en_in, pool_oversub_in;
	logic pkt_valid_in, pkt_high_prio_in, red_grant_in, drain_valid_in;
	logic [LEN_W-1:0] pkt_len_in, drain_len_in, tx_wire_len_out;
	logic [LEAK_W-1:0] shape_leak_in;
	logic cfg_err_out, pkt_done_out, pkt_accept_out, pkt_drop_out, tx_done_out;
	logic [ADJ_W-1:0] pkt_acct_len_out, tx_acct_len_out;
	logic shape_open_out, wire_cap_out;
	logic [BYTES_W-1:0] burst_bytes_out, occupancy_out;
	logic [STAT_W-1:0] stat_bytes_out;
	int error_cnt = 0;
	int n_tests = 0;
	logic sub_e = 1'b0;
	logic [AMT_W-1:0] amt_e = '0;
	logic [31:0] occ_e = '0;
	logic [31:0] stat_e = '0;

	queue_buffer_admission_shaping queue_buffer_admission_shaping_inst (
		.core_clk_in, .rst_b_in, .burst_wr_in, .burst_op_in, .burst_size_in,
		.burst_in_bytes_in, .cbs_wr_in, .cbs_kb_in, .mbs_wr_in, .mbs_size_in,
		.mbs_in_bytes_in, .hp_wr_in, .hp_pct_in, .adj_wr_in, .adj_sub_in, .adj_amount_in,
		.ingress_queue_in, .wire_acct_en_in, .pool_oversub_in, .pkt_valid_in,
		.pkt_len_in, .pkt_high_prio_in, .red_grant_in, .drain_valid_in, .drain_len_in,
		.shape_leak_in, .cfg_err_out, .pkt_done_out, .pkt_accept_out, .pkt_drop_out,
		.pkt_acct_len_out, .tx_done_out, .tx_acct_len_out, .tx_wire_len_out,
		.shape_open_out, .burst_bytes_out, .occupancy_out, .stat_bytes_out, .wire_cap_out
	);

	queue_partner queue_partner_inst (
		.core_clk_in, .pkt_valid_out(pkt_valid_in), .pkt_len_out(pkt_len_in),
		.pkt_high_prio_out(pkt_high_prio_in), .red_grant_out(red_grant_in),
		.drain_valid_out(drain_valid_in), .drain_len_out(drain_len_in),
		.shape_leak_out(shape_leak_in)
	);

	// ==========================================================
	// clock, 4 ns period
	initial begin
		core_clk_in = 1'b0;
		forever #2 core_clk_in = ~core_clk_in;
	end

	// ==========================================================
	// comparison, closing and shared access tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("checks=%0d mismatches=%0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// strobes are one-cycle pulses; the error pulse stands only in the cycle after
	task automatic cfg_end(input logic err);
		@(negedge core_clk_in);
		chk(32'(cfg_err_out), 32'(err));
		burst_wr_in = 1'b0;
		cbs_wr_in = 1'b0;
		mbs_wr_in = 1'b0;
		hp_wr_in = 1'b0;
		adj_wr_in = 1'b0;
	endtask

	task automatic burst(input burst_op_t op, input logic [SZ_W-1:0] sz, input logic byt,
		input logic err, input logic [BYTES_W-1:0] bb);
		@(negedge core_clk_in);
		burst_wr_in = 1'b1;
		burst_op_in = op;
		burst_size_in = sz;
		burst_in_bytes_in = byt;
		cfg_end(err);
		@(negedge core_clk_in);
		chk(32'(burst_bytes_out), 32'(bb));
	endtask

	task automatic bufw(input logic cw, input logic [SZ_W-1:0] c, input logic mw,
		input logic [SZ_W-1:0] m, input logic mbyt, input logic err);
		@(negedge core_clk_in);
		cbs_wr_in = cw;
		cbs_kb_in = c;
		mbs_wr_in = mw;
		mbs_size_in = m;
		mbs_in_bytes_in = mbyt;
		cfg_end(err);
	endtask

	task automatic adjw(input logic sub, input logic [AMT_W-1:0] amt, input logic err);
		@(negedge core_clk_in);
		adj_wr_in = 1'b1;
		adj_sub_in = sub;
		adj_amount_in = amt;
		cfg_end(err);
		if (!err) begin
			sub_e = sub;
			amt_e = amt;
		end
	endtask

	task automatic hpw(input logic [PCT_W-1:0] pct, input logic err);
		@(negedge core_clk_in);
		hp_wr_in = 1'b1;
		hp_pct_in = pct;
		cfg_end(err);
	endtask

	// accounting length worked out here, with a floor of zero on subtract
	function automatic logic [31:0] acct(input logic [LEN_W-1:0] len);
		if (sub_e) begin
			return (32'(len) > 32'(amt_e)) ? 32'(len) - 32'(amt_e) : 32'h0;
		end
		return 32'(len) + 32'(amt_e);
	endfunction

	task automatic admit(input logic [LEN_W-1:0] len, input logic hi, input logic grant,
		input logic acc);
		// verdict pulses last one cycle, so they are read at the release edge
		queue_partner_inst.arrive(len, hi, grant);
		chk(32'(pkt_done_out), 32'h1);
		chk(32'({pkt_accept_out, pkt_drop_out}), acc ? 32'h2 : 32'h1);
		if (acc) begin
			occ_e = occ_e + 32'(len);
			stat_e = stat_e + acct(len);
			chk(32'(pkt_acct_len_out), acct(len));
		end
		chk(32'(occupancy_out), occ_e);
		chk(stat_bytes_out, stat_e);
	endtask

	task automatic drain(input logic [LEN_W-1:0] len);
		queue_partner_inst.depart(len);
		occ_e = (occ_e > 32'(len)) ? occ_e - 32'(len) : 32'h0;
		chk(32'(tx_done_out), 32'h1);
		chk(32'(tx_acct_len_out), acct(len));
		chk(32'(tx_wire_len_out), 32'(len));
		chk(32'(occupancy_out), occ_e);
	endtask

	// ==========================================================
	// watchdog, far beyond the roughly 115 cycles the sequence needs
	initial begin
		#20000;
		error_cnt++;
		give_verdict();
	end

	// ==========================================================
	// main sequence
	initial begin
		{rst_b_in, burst_wr_in, burst_in_bytes_in, cbs_wr_in, mbs_wr_in} = '0;
		{mbs_in_bytes_in, hp_wr_in, adj_wr_in, adj_sub_in} = '0;
		{ingress_queue_in, wire_acct_en_in, pool_oversub_in} = '0;
		burst_op_in = BURST_SET_POLICY;
		{burst_size_in, cbs_kb_in, mbs_size_in} = '0;
		hp_pct_in = '0;
		adj_amount_in = '0;
		repeat (16) @(negedge core_clk_in);
		rst_b_in = 1'b1;
		@(negedge core_clk_in);
		chk(32'(burst_bytes_out), 32'(BURST_SYS_RST));
		chk(32'(occupancy_out), 32'h0);
		burst(BURST_SET_INST, 18'h00005, 1'b1, 1'b0, 28'h0000005);
		burst(BURST_SET_POLICY, 18'h00003, 1'b0, 1'b0, 28'h0000005);
		burst(BURST_CLR_INST, 18'h00000, 1'b0, 1'b0, 28'h0000bb8);
		burst(BURST_CLR_POLICY, 18'h00000, 1'b0, 1'b0, BURST_SYS_RST);
		burst(BURST_SET_POLICY, 18'h00000, 1'b1, 1'b1, BURST_SYS_RST);
		burst(BURST_SET_POLICY, 18'h036b1, 1'b1, 1'b1, BURST_SYS_RST);
		burst(BURST_SET_POLICY, 18'h036b0, 1'b0, 1'b0, 28'h0d59f80);
		burst(BURST_SET_INST, 18'h00064, 1'b1, 1'b0, 28'h0000064);
		adjw(1'b0, 7'h21, 1'b1);
		adjw(1'b1, 7'h41, 1'b1);
		adjw(1'b0, 7'h20, 1'b0);
		adjw(1'b1, 7'h40, 1'b0);
		adjw(1'b0, 7'h04, 1'b0);
		admit(14'h0064, 1'b0, 1'b0, 1'b0);
		admit(14'h0064, 1'b0, 1'b1, 1'b1);
		bufw(1'b1, 18'h00000, 1'b1, 18'h00000, 1'b0, 1'b0);
		admit(14'h000a, 1'b0, 1'b1, 1'b0);
		bufw(1'b0, 18'h00000, 1'b1, 18'h20001, 1'b0, 1'b1);
		bufw(1'b1, 18'h20001, 1'b0, 18'h00000, 1'b0, 1'b1);
		bufw(1'b0, 18'h00000, 1'b1, 18'h000c8, 1'b1, 1'b0);
		bufw(1'b1, 18'h00001, 1'b0, 18'h00000, 1'b0, 1'b1);
		admit(14'h0096, 1'b0, 1'b1, 1'b1);
		admit(14'h000a, 1'b0, 1'b1, 1'b0);
		drain(14'h0064);
		chk(32'(shape_open_out), 32'h0);
		queue_partner_inst.set_leak(16'h03e8);
		drain(14'h000a);
		chk(32'(shape_open_out), 32'h1);
		queue_partner_inst.set_leak(16'h0000);
		admit(14'h000a, 1'b0, 1'b1, 1'b1);
		bufw(1'b1, 18'h20000, 1'b1, 18'h20000, 1'b0, 1'b0);
		admit(14'h000a, 1'b0, 1'b0, 1'b1);
		@(negedge core_clk_in);
		pool_oversub_in = 1'b1;
		admit(14'h000a, 1'b0, 1'b0, 1'b0);
		pool_oversub_in = 1'b0;
		hpw(7'h65, 1'b1);
		hpw(7'h64, 1'b0);
		admit(14'h000a, 1'b0, 1'b1, 1'b1);
		ingress_queue_in = 1'b1;
		admit(14'h000a, 1'b0, 1'b1, 1'b0);
		admit(14'h000a, 1'b1, 1'b1, 1'b1);
		hpw(7'h00, 1'b0);
		admit(14'h000a, 1'b0, 1'b1, 1'b1);
		ingress_queue_in = 1'b0;
		adjw(1'b1, 7'h40, 1'b0);
		admit(14'h0032, 1'b0, 1'b1, 1'b1);
		drain(14'h003c);
		wire_acct_en_in = 1'b1;
		@(negedge core_clk_in);
		chk(32'(wire_cap_out), 32'h1);
		admit(14'h0064, 1'b0, 1'b1, 1'b1);
		// mid-run reset must restore defaults and clear the counters
		@(negedge core_clk_in);
		rst_b_in = 1'b0;
		repeat (2) @(negedge core_clk_in);
		rst_b_in = 1'b1;
		chk(32'(burst_bytes_out), 32'(BURST_SYS_RST));
		chk(32'(occupancy_out), 32'h0);
		chk(stat_bytes_out, 32'h0);
		occ_e = '0;
		stat_e = '0;
		sub_e = 1'b0;
		amt_e = ADJ_AMT_RST;
		admit(14'h000a, 1'b0, 1'b1, 1'b1);
		give_verdict();
	end
endmodule
`default_nettype wire
